// ==== include/prisq_consts.svh ====
`ifndef PRISQ_CONSTS_SVH
`define PRISQ_CONSTS_SVH
`define PRISQ_ADDR_STATUS  8'h00
`define PRISQ_ADDR_MASK    8'h04
`define PRISQ_ADDR_CTRL    8'h08
`define PRISQ_ADDR_STATE   8'h0C
`define PRISQ_ADDR_ACCUM   8'h10
`define PRISQ_ADDR_FLAGS   8'h14
`define PRISQ_ADDR_IP      8'h18
`define PRISQ_ADDR_MODE0   8'h1C
`define PRISQ_FLAGS_RST    32'h00000002
`define PRISQ_FLAGS_FIXED  32'h00000002
`define PRISQ_IP_RST       32'h0000FFF0
`define PRISQ_MODE0_RST    32'h60000010
`define PRISQ_ACCUM_RST    32'h00000000
`define PRISQ_FAIL_CODE    32'h00000001
`define PRISQ_CTRL_RST     3'h0
`define PRISQ_CTRL_DUAL    0
`define PRISQ_CTRL_PRIM    1
`define PRISQ_CTRL_SINGLE  2
`define PRISQ_EV_HARD      0
`define PRISQ_EV_SOFT      1
`define PRISQ_EV_FAIL      2
`define PRISQ_EV_START     3
`define PRISQ_EV_W         4
`define PRISQ_SELFTEST_CYC 30000000
`endif

// ==== include/prisq_pkg.sv ====
package prisq_pkg;
  // Sequencer states; hold covers both pins, inval is a single cycle.
  typedef enum logic [3:0] {
    S_HOLD,
    S_INVAL,
    S_TEST,
    S_ELECT,
    S_BOOT,
    S_WAIT,
    S_HALT,
    S_APP
  } prisq_state_t;
endpackage

// ==== rtl/prisq_sequencer.sv ====
`timescale 1ns/1ps
`include "prisq_consts.svh"
module prisq_sequencer #(
  parameter int ST_CNT_W        = 25,
  parameter int SELFTEST_CYCLES = `PRISQ_SELFTEST_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_hard_reset_n,
  input  wire logic        i_soft_init_n,
  input  wire logic        i_selftest_req,
  input  wire logic        i_selftest_fault,
  input  wire logic        i_elect_done,
  input  wire logic        i_elect_won,
  input  wire logic        i_startup_msg,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_irq,
  output logic             o_cache_inval,
  output logic             o_tlb_inval,
  output logic             o_btb_inval,
  output logic             o_fpu_init,
  output logic             o_elect_req,
  output logic             o_fetch_en,
  output logic             o_is_boot_core,
  output logic             o_wait_startup,
  output logic             o_halted,
  output logic      [31:0] o_fetch_ip,
  output logic      [31:0] o_flags,
  output logic      [31:0] o_mode0,
  output logic      [31:0] o_accum
);
  // Two-stage synchronisers for the pin, strap, fault and election inputs; i_startup_msg is used directly.
  logic [5:0] sync1_reg;                // First stage, read only by stage two.
  logic [5:0] sync2_reg;                // Second stage, safe to use.
  // Pin inputs come from the platform and from bus peers asynchronously.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sync1_reg <= 6'h03;
      sync2_reg <= 6'h03;
    end
    else
    begin
      sync1_reg <= {i_elect_won, i_elect_done, i_selftest_fault,
                    i_selftest_req, ~i_soft_init_n, ~i_hard_reset_n};
      sync2_reg <= sync1_reg;
    end
  end
  wire hard_s   = sync2_reg[0];         // Reset pin asserted.
  wire init_s   = sync2_reg[1];         // Soft init pin asserted.
  wire streq_s  = sync2_reg[2];         // Self-test strap.
  wire fault_s  = sync2_reg[3];         // Self-test engine fault flag.
  wire edone_s  = sync2_reg[4];         // Election finished on the bus.
  wire ewon_s   = sync2_reg[5];         // This core won the election.
  // Sequencer state and bookkeeping.
  prisq_pkg::prisq_state_t state_reg;   // Current state.
  prisq_pkg::prisq_state_t state_next;  // Next state.
  logic                    hard_kind_reg; // Current sequence is a full reset.
  logic                    powerup_reg; // First sequence since power-up.
  logic                    fault_seen_reg; // Fault seen during self-test.
  logic [ST_CNT_W-1:0]     test_cnt_reg; // Self-test cycle counter.
  // Architectural registers and block registers.
  logic [31:0]             flags_reg;   // Status flags word.
  logic [31:0]             ip_reg;      // Instruction pointer.
  logic [31:0]             mode0_reg;   // Mode control zero.
  logic [31:0]             accum_reg;   // Accumulator, self-test result.
  logic [2:0]              ctrl_reg;    // Variant selection bits.
  logic [`PRISQ_EV_W-1:0]  status_reg;  // Sticky events.
  logic [`PRISQ_EV_W-1:0]  mask_reg;    // Interrupt enables.
  logic [31:0]             rdata_reg;   // Read data, one cycle late.
  logic                    irq_reg;     // Interrupt level.
  // Output pulses and levels, all registered.
  logic cache_inv_reg;
  logic tlb_inv_reg;
  logic btb_inv_reg;
  logic fpu_init_reg;
  logic elect_req_reg;
  logic fetch_en_reg;
  logic boot_core_reg;
  logic wait_reg;
  logic halt_reg;
  // Address decode.
  wire sel_status = (i_addr == `PRISQ_ADDR_STATUS);
  wire sel_mask   = (i_addr == `PRISQ_ADDR_MASK);
  wire sel_ctrl   = (i_addr == `PRISQ_ADDR_CTRL);
  wire sel_state  = (i_addr == `PRISQ_ADDR_STATE);
  wire sel_accum  = (i_addr == `PRISQ_ADDR_ACCUM);
  wire sel_flags  = (i_addr == `PRISQ_ADDR_FLAGS);
  wire sel_ip     = (i_addr == `PRISQ_ADDR_IP);
  wire sel_mode0  = (i_addr == `PRISQ_ADDR_MODE0);
  // Variant controls.
  wire dual_mode   = ctrl_reg[`PRISQ_CTRL_DUAL];
  wire primary     = ctrl_reg[`PRISQ_CTRL_PRIM];
  wire single_core = ctrl_reg[`PRISQ_CTRL_SINGLE];
  // The reset pin wins whenever both pins are low together.
  wire enter_hard = hard_s;
  wire enter_soft = init_s && !hard_s;
  wire in_hold    = (state_reg == prisq_pkg::S_HOLD);
  wire leave_hold = in_hold && !hard_s && !init_s;
  // Self-test runs only on the power-up sequence when strapped for it.
  wire test_go    = hard_kind_reg && powerup_reg && streq_s;
  wire test_done  = (test_cnt_reg == ST_CNT_W'(SELFTEST_CYCLES - 1));
  // Events feeding the sticky status register.
  wire ev_hard  = (state_reg == prisq_pkg::S_INVAL) && hard_kind_reg;
  wire ev_soft  = (state_reg == prisq_pkg::S_INVAL) && !hard_kind_reg;
  wire ev_fail  = (state_reg == prisq_pkg::S_TEST) && test_done &&
                  (fault_seen_reg || fault_s);
  wire ev_start = i_startup_msg &&
                  ((state_reg == prisq_pkg::S_WAIT) || (state_reg == prisq_pkg::S_HALT));
  wire [`PRISQ_EV_W-1:0] ev_vec = {ev_start, ev_fail, ev_soft, ev_hard};
  // Set wins over a write-one clear arriving in the same cycle.
  wire [`PRISQ_EV_W-1:0] clr_vec =
    (i_wr && sel_status) ? i_wdata[`PRISQ_EV_W-1:0] : {`PRISQ_EV_W{1'b0}};
  wire [`PRISQ_EV_W-1:0] status_next = (status_reg & ~clr_vec) | ev_vec;
  wire                   irq_next    = |(status_next & mask_reg);
  // Read mux; unmapped addresses read as zero.
  wire [31:0] rd_mux =
    sel_status ? {{(32-`PRISQ_EV_W){1'b0}}, status_reg} :
    sel_mask   ? {{(32-`PRISQ_EV_W){1'b0}}, mask_reg}   :
    sel_ctrl   ? {29'h0, ctrl_reg}                      :
    sel_state  ? {28'h0, state_reg}                     :
    sel_accum  ? accum_reg                              :
    sel_flags  ? flags_reg                              :
    sel_ip     ? ip_reg                                 :
    sel_mode0  ? mode0_reg                              : 32'h0;
  // Next-state logic; any pin overrides the current phase.
  always_comb
  begin
    state_next = state_reg;
    if (enter_hard || enter_soft)
      state_next = prisq_pkg::S_HOLD;
    else
      case (state_reg)
        // Release of both pins starts the invalidation step.
        prisq_pkg::S_HOLD:
          state_next = prisq_pkg::S_INVAL;
        prisq_pkg::S_INVAL:
          state_next = test_go ? prisq_pkg::S_TEST : prisq_pkg::S_ELECT;
        prisq_pkg::S_TEST:
          if (test_done)
            state_next = prisq_pkg::S_ELECT;
        prisq_pkg::S_ELECT:
        begin
          // Dual variant needs no contention; the primary control bit decides.
          if (dual_mode)
            state_next = primary ? prisq_pkg::S_BOOT : prisq_pkg::S_HALT;
          else if (single_core)
            state_next = prisq_pkg::S_BOOT;
          else if (edone_s)
            state_next = ewon_s ? prisq_pkg::S_BOOT : prisq_pkg::S_WAIT;
        end
        // Parked until the bootstrap core sends its message.
        prisq_pkg::S_WAIT, prisq_pkg::S_HALT:
          if (i_startup_msg)
            state_next = prisq_pkg::S_APP;
        default:
          state_next = state_reg;
      endcase
  end
  // State register; power-up enters hold as a full reset.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      state_reg <= prisq_pkg::S_HOLD;
    else
      state_reg <= state_next;
  end
  // Kind of sequence; a soft pin arriving during hold cannot downgrade a hard one.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      hard_kind_reg <= 1'b1;
      powerup_reg   <= 1'b1;
    end
    else
    begin
      if (enter_hard)
        hard_kind_reg <= 1'b1;
      else if (enter_soft && !in_hold)
        hard_kind_reg <= 1'b0;
      if (state_reg == prisq_pkg::S_INVAL)
        powerup_reg <= 1'b0;
    end
  end
  // Self-test counter and fault collection; both clear outside the test phase.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      test_cnt_reg   <= '0;
      fault_seen_reg <= 1'b0;
    end
    else
    begin
      test_cnt_reg   <= (state_reg == prisq_pkg::S_TEST) ? test_cnt_reg + 1'b1 : '0;
      fault_seen_reg <= (state_reg == prisq_pkg::S_TEST) && (fault_seen_reg || fault_s);
    end
  end
  // Invalidation and fpu pulses, one cycle each; soft init spares caches.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cache_inv_reg <= 1'b0;
      tlb_inv_reg   <= 1'b0;
      btb_inv_reg   <= 1'b0;
      fpu_init_reg  <= 1'b0;
    end
    else
    begin
      cache_inv_reg <= ev_hard;
      fpu_init_reg  <= ev_hard;
      tlb_inv_reg   <= ev_hard || ev_soft;
      btb_inv_reg   <= ev_hard || ev_soft;
    end
  end
  // Role outputs follow the next state so they line up with it.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      elect_req_reg <= 1'b0;
      fetch_en_reg  <= 1'b0;
      boot_core_reg <= 1'b0;
      wait_reg      <= 1'b0;
      halt_reg      <= 1'b0;
    end
    else
    begin
      elect_req_reg <= (state_next == prisq_pkg::S_ELECT) && !dual_mode && !single_core;
      fetch_en_reg  <= (state_next == prisq_pkg::S_BOOT) ||
                       (state_next == prisq_pkg::S_APP);
      boot_core_reg <= (state_next == prisq_pkg::S_BOOT);
      wait_reg      <= (state_next == prisq_pkg::S_WAIT);
      halt_reg      <= (state_next == prisq_pkg::S_HALT);
    end
  end
  // Architectural registers; the hold phase reloads them every cycle,
  // so a software write during hold is lost on purpose.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      flags_reg <= `PRISQ_FLAGS_RST;
      ip_reg    <= `PRISQ_IP_RST;
      mode0_reg <= `PRISQ_MODE0_RST;
    end
    else if (in_hold)
    begin
      flags_reg <= `PRISQ_FLAGS_RST;
      ip_reg    <= `PRISQ_IP_RST;
      mode0_reg <= `PRISQ_MODE0_RST;
    end
    else if (i_wr)
    begin
      // The fixed flag bit always reads as one.
      if (sel_flags)
        flags_reg <= i_wdata | `PRISQ_FLAGS_FIXED;
      if (sel_ip)
        ip_reg <= i_wdata;
      if (sel_mode0)
        mode0_reg <= i_wdata;
    end
  end
  // Accumulator: cleared by a hard reset, loaded with the test verdict.
  // A soft init leaves it alone, so software keeps any earlier verdict.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      accum_reg <= `PRISQ_ACCUM_RST;
    else if (ev_hard)
      accum_reg <= `PRISQ_ACCUM_RST;
    else if ((state_reg == prisq_pkg::S_TEST) && test_done)
      accum_reg <= ev_fail ? `PRISQ_FAIL_CODE : `PRISQ_ACCUM_RST;
  end
  // Block registers, bus read data and interrupt level.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ctrl_reg   <= `PRISQ_CTRL_RST;
      mask_reg   <= '0;
      status_reg <= '0;
      rdata_reg  <= 32'h0;
      irq_reg    <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg    <= irq_next;
      rdata_reg  <= i_rd ? rd_mux : 32'h0;
      if (i_wr && sel_ctrl)
        ctrl_reg <= i_wdata[2:0];
      if (i_wr && sel_mask)
        mask_reg <= i_wdata[`PRISQ_EV_W-1:0];
    end
  end
  // Outputs straight from flops.
  assign o_rdata        = rdata_reg;
  assign o_irq          = irq_reg;
  assign o_cache_inval  = cache_inv_reg;
  assign o_tlb_inval    = tlb_inv_reg;
  assign o_btb_inval    = btb_inv_reg;
  assign o_fpu_init     = fpu_init_reg;
  assign o_elect_req    = elect_req_reg;
  assign o_fetch_en     = fetch_en_reg;
  assign o_is_boot_core = boot_core_reg;
  assign o_wait_startup = wait_reg;
  assign o_halted       = halt_reg;
  assign o_fetch_ip     = ip_reg;
  assign o_flags        = flags_reg;
  assign o_mode0        = mode0_reg;
  assign o_accum        = accum_reg;
  // Checks on the sequencer.
  property p_release_inval;
    @(posedge i_ref_clk) disable iff (i_reset)
    (in_hold && !hard_s && !init_s) |=> (state_reg == prisq_pkg::S_INVAL);
  endproperty
  a_release_inval: assert property (p_release_inval)
    else $error("Release of pins did not start invalidation.");
  property p_reload;
    @(posedge i_ref_clk) disable iff (i_reset)
    in_hold |=> (mode0_reg == `PRISQ_MODE0_RST) && (ip_reg == `PRISQ_IP_RST) &&
                (flags_reg == `PRISQ_FLAGS_RST);
  endproperty
  a_reload: assert property (p_reload)
    else $error("Architectural values not reloaded in hold.");
  property p_hard_inval;
    @(posedge i_ref_clk) disable iff (i_reset)
    ev_hard |=> o_cache_inval && o_fpu_init && o_tlb_inval && o_btb_inval;
  endproperty
  a_hard_inval: assert property (p_hard_inval)
    else $error("Hard reset missed an invalidation pulse.");
  property p_soft_keep;
    @(posedge i_ref_clk) disable iff (i_reset)
    ev_soft |=> !o_cache_inval && !o_fpu_init && o_tlb_inval && o_btb_inval;
  endproperty
  a_soft_keep: assert property (p_soft_keep)
    else $error("Soft init pulses wrong.");
  property p_prio;
    @(posedge i_ref_clk) disable iff (i_reset)
    (hard_s && init_s) |=> in_hold && hard_kind_reg;
  endproperty
  a_prio: assert property (p_prio)
    else $error("Soft init overrode reset pin.");
  property p_no_test_zero;
    @(posedge i_ref_clk) disable iff (i_reset)
    (ev_hard && !test_go) |=> ##1 (accum_reg == `PRISQ_ACCUM_RST);
  endproperty
  a_no_test_zero: assert property (p_no_test_zero)
    else $error("Accumulator not zero after plain reset.");
  property p_verdict;
    @(posedge i_ref_clk) disable iff (i_reset)
    ((state_reg == prisq_pkg::S_TEST) && test_done) |=>
      ((accum_reg != `PRISQ_ACCUM_RST) == $past(ev_fail));
  endproperty
  a_verdict: assert property (p_verdict)
    else $error("Self-test verdict wrong.");
  property p_single;
    @(posedge i_ref_clk) disable iff (i_reset)
    ((state_reg == prisq_pkg::S_ELECT) && single_core && !dual_mode && !hard_s && !init_s)
      |=> (state_reg == prisq_pkg::S_BOOT) && o_fetch_en;
  endproperty
  a_single: assert property (p_single)
    else $error("Lone core did not boot.");
  property p_dual;
    @(posedge i_ref_clk) disable iff (i_reset)
    ((state_reg == prisq_pkg::S_ELECT) && dual_mode && !hard_s && !init_s)
      |=> (primary ? o_fetch_en : o_halted);
  endproperty
  a_dual: assert property (p_dual)
    else $error("Dual variant role wrong.");
  property p_wait;
    @(posedge i_ref_clk) disable iff (i_reset)
    ((state_reg == prisq_pkg::S_WAIT) && !i_startup_msg && !hard_s && !init_s)
      |=> o_wait_startup && !o_fetch_en;
  endproperty
  a_wait: assert property (p_wait)
    else $error("Waiting core left without startup message.");
  property p_elect;
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_elect_req && edone_s && ewon_s && !hard_s && !init_s && !dual_mode && !single_core)
      |=> o_fetch_en && o_is_boot_core && (o_fetch_ip == ip_reg);
  endproperty
  a_elect: assert property (p_elect)
    else $error("Elected core did not fetch.");
  c_boot: cover property (@(posedge i_ref_clk) disable iff (i_reset) o_is_boot_core);
  c_app: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    o_wait_startup ##1 (state_reg == prisq_pkg::S_APP));
  c_fail: cover property (@(posedge i_ref_clk) disable iff (i_reset) ev_fail);
  c_soft: cover property (@(posedge i_ref_clk) disable iff (i_reset) ev_soft);
endmodule

// ==== test/prisq_peer_model.sv ====
`timescale 1ns/1ps
// Peer processors on the shared bus: they settle the election after a set delay.
module prisq_peer_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_elect_req,
  input  wire logic       i_win,
  input  wire logic [3:0] i_delay,
  output logic            o_elect_done,
  output logic            o_elect_won
);
  logic [3:0] wait_reg; // Cycles spent in the current election.
  initial
  begin
    wait_reg     = 4'h0;
    o_elect_done = 1'b0;
    o_elect_won  = 1'b0;
  end
  // Done stands while the request does; won means nothing outside done, so it toggles.
  always @(posedge i_ref_clk)
  begin
    if (!i_elect_req)
    begin
      wait_reg     <= 4'h0;
      o_elect_done <= 1'b0;
      o_elect_won  <= ~o_elect_won;
    end
    else if (wait_reg == i_delay)
    begin
      o_elect_done <= 1'b1;
      o_elect_won  <= i_win;
    end
    else
      wait_reg <= wait_reg + 4'h1;
  end
endmodule

// ==== test/prisq_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`include "prisq_consts.svh"
// Drives pins, straps and the register bus, and checks each reset sequence.
module prisq_sequencer_tb_top;
  localparam int ST = 16; // Short self-test so the run stays brief.
  logic        i_ref_clk = 1'b0;
  logic        i_reset   = 1'b1;
  logic        hard_n    = 1'b1; // Reset pin, low asserts.
  logic        soft_n    = 1'b1; // Soft init pin, low asserts.
  logic        st_req    = 1'b0;
  logic        st_fault  = 1'b0;
  logic        startup   = 1'b0;
  logic [7:0]  i_addr    = 8'h00;
  logic [31:0] i_wdata   = 32'h0;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic        win       = 1'b1; // Whether the peers let this core win.
  logic [3:0]  dly       = 4'h2;
  logic        clr       = 1'b0;
  logic [3:0]  seen      = 4'h0; // Invalidate and fpu pulses seen since clr.
  logic        el_seen   = 1'b0; // Election request seen since clr.
  logic        done, won;
  logic [31:0] o_rdata, o_fetch_ip, o_flags, o_mode0, o_accum;
  logic        o_irq, o_cache_inval, o_tlb_inval, o_btb_inval, o_fpu_init;
  logic        o_elect_req, o_fetch_en, o_is_boot_core, o_wait_startup, o_halted;
  logic [31:0] seed = 32'h35;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n0, n1, n;

  always #10 i_ref_clk = ~i_ref_clk;

  // Pulses last one cycle, so they are gathered here rather than polled.
  always @(posedge i_ref_clk)
  begin
    seen    <= clr ? 4'h0 : seen | {o_cache_inval, o_tlb_inval, o_btb_inval, o_fpu_init};
    el_seen <= clr ? 1'b0 : el_seen | o_elect_req;
  end

  prisq_sequencer #(.ST_CNT_W(25), .SELFTEST_CYCLES(ST)) prisq_sequencer_i (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_hard_reset_n(hard_n),
    .i_soft_init_n(soft_n), .i_selftest_req(st_req), .i_selftest_fault(st_fault),
    .i_elect_done(done), .i_elect_won(won), .i_startup_msg(startup),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_cache_inval(o_cache_inval), .o_tlb_inval(o_tlb_inval),
    .o_btb_inval(o_btb_inval), .o_fpu_init(o_fpu_init), .o_elect_req(o_elect_req),
    .o_fetch_en(o_fetch_en), .o_is_boot_core(o_is_boot_core),
    .o_wait_startup(o_wait_startup), .o_halted(o_halted), .o_fetch_ip(o_fetch_ip),
    .o_flags(o_flags), .o_mode0(o_mode0), .o_accum(o_accum));

  prisq_peer_model prisq_peer_model_i (.i_ref_clk(i_ref_clk), .i_elect_req(o_elect_req),
    .i_win(win), .i_delay(dly), .o_elect_done(done), .o_elect_won(won));

  // Xorshift step; the seed starts at 53 so every run is the same.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // The flags word always reads back with its fixed bit set.
  function automatic logic [31:0] flags_exp(input logic [31:0] v);
    return v | `PRISQ_FLAGS_FIXED;
  endfunction

  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  // Bounded wait for a role (sel 0) or for the election request (sel 1).
  task wait_for(input logic sel, output int cnt);
    cnt = 0;
    #1;
    while ((sel ? o_elect_req : (o_fetch_en | o_wait_startup | o_halted)) !== 1'b1)
    begin
      if (cnt == 300)
      begin
        n_errors++;
        give_verdict();
      end
      @(posedge i_ref_clk);
      #1 cnt++;
    end
  endtask

  task power(input logic req, input logic fault, output int cnt);
    @(posedge i_ref_clk);
    i_reset  <= 1'b1;
    st_req   <= req;
    st_fault <= fault;
    clr      <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    clr     <= 1'b0;
    wait_for(1'b1, cnt);
    wait_for(1'b0, n);
  endtask

  // Pins are held four cycles so the synchronisers surely see them.
  task pins(input logic h, input logic s);
    seed = xs(seed);
    @(posedge i_ref_clk);
    clr    <= 1'b1;
    hard_n <= ~h;
    soft_n <= ~s;
    dly    <= seed[3:0];
    repeat (4) @(posedge i_ref_clk);
    clr    <= 1'b0;
    hard_n <= 1'b1;
    soft_n <= 1'b1;
    wait_for(1'b0, n);
  endtask

  task send_startup;
    @(posedge i_ref_clk);
    startup <= 1'b1;
    @(posedge i_ref_clk);
    startup <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask

  initial
  begin
    power(1'b0, 1'b0, n0);
    chk(32'(seen), 32'hF);
    chk(o_fetch_ip, `PRISQ_IP_RST);
    chk(32'(o_is_boot_core), 32'h1);
    rd(`PRISQ_ADDR_FLAGS, `PRISQ_FLAGS_RST);
    rd(`PRISQ_ADDR_MODE0, `PRISQ_MODE0_RST);
    rd(`PRISQ_ADDR_ACCUM, `PRISQ_ACCUM_RST);
    rd(`PRISQ_ADDR_STATUS, 32'h1);
    rd(8'h40, 32'h0);
    $display("test power_up done");
    // Soft init after software changed the registers; this core loses the election.
    seed = xs(seed);
    wr(`PRISQ_ADDR_IP, seed);
    rd(`PRISQ_ADDR_IP, seed);
    wr(`PRISQ_ADDR_FLAGS, seed & 32'hFFFFFFFD);
    rd(`PRISQ_ADDR_FLAGS, flags_exp(seed));
    wr(`PRISQ_ADDR_MODE0, ~seed);
    wr(`PRISQ_ADDR_MASK, 32'h8);
    wr(`PRISQ_ADDR_STATUS, 32'hF);
    win <= 1'b0;
    pins(1'b0, 1'b1);
    chk(32'(seen), 32'h6);
    chk(o_fetch_ip, `PRISQ_IP_RST);
    chk(o_flags, `PRISQ_FLAGS_RST);
    chk(o_mode0, `PRISQ_MODE0_RST);
    chk(32'(o_wait_startup), 32'h1);
    chk(32'(o_irq), 32'h0);
    send_startup();
    chk(32'(o_fetch_en), 32'h1);
    chk(32'(o_irq), 32'h1);
    wr(`PRISQ_ADDR_STATUS, 32'h8);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(32'(o_irq), 32'h0);
    rd(`PRISQ_ADDR_STATUS, 32'h2);
    $display("test soft_init done");
    // Both pins at once must give the full reset.
    win <= 1'b1;
    wr(`PRISQ_ADDR_STATUS, 32'hF);
    pins(1'b1, 1'b1);
    chk(32'(seen), 32'hF);
    rd(`PRISQ_ADDR_STATUS, 32'h1);
    $display("test both_pins done");
    wr(`PRISQ_ADDR_CTRL, 32'h4);
    pins(1'b1, 1'b0);
    chk(32'(el_seen), 32'h0);
    chk(32'(o_is_boot_core), 32'h1);
    wr(`PRISQ_ADDR_CTRL, 32'h3);
    pins(1'b1, 1'b0);
    chk(32'(o_fetch_en), 32'h1);
    wr(`PRISQ_ADDR_CTRL, 32'h1);
    pins(1'b1, 1'b0);
    chk(32'(o_halted), 32'h1);
    chk(32'(o_fetch_en), 32'h0);
    send_startup();
    chk(32'(o_fetch_en), 32'h1);
    $display("test boot_modes done");
    power(1'b1, 1'b1, n1);
    chk(o_accum, `PRISQ_FAIL_CODE);
    chk(32'(n1 - n0), 32'(ST));
    rd(`PRISQ_ADDR_STATUS, 32'h5);
    power(1'b1, 1'b0, n1);
    chk(o_accum, `PRISQ_ACCUM_RST);
    chk(32'(n1 - n0), 32'(ST));
    $display("test selftest done");
    give_verdict();
  end
endmodule
